// file: shared/gsw_pkg.sv
// What this block does
// [R01] Status word fills input bytes zero and one
// [R02] Bit 15 send, bit 14 confirm handshake
// [R03] Master modes: sticky valid after all transactions
// [R04] Generic mode: valid bit unused, reads zero
// [R05] Bits 12:8 last code, 7:0 data
// [R06] High byte stored first, at offset zero
// [R07] Master: retransmission increase gives warning 0x00
// [R08] Master: one node missing, error 0x01
// [R09] Master: several missing, error 0x02 count
// [R10] Master: overrun warning 0x03, other error 0x04
// [R11] Error codes later followed by 0x1F
// [R12] Warnings need no following 0x1F report
// [R13] Generic: invalid transaction increase, error 0x00
// [R14] Generic: delimiter timeout frame warning 0x01
// [R15] Generic: offline timeout increase, error 0x02
// [R16] Generic: overrun warning 0x03, other 0x04
// [R17] Code table chosen by operating mode
// [R18] Word appears only when enabled
// [R19] Valid cleared at online and at offline, never otherwise; bit 13 of the word also reads zero whenever mode is generic
// [R20] Code and data update together
package gsw_pkg;

    localparam int            GSW_AREA_AW      = 9;
    localparam logic [8:0]    GSW_OFS_WORD_HI  = 9'h000;
    localparam logic [8:0]    GSW_OFS_WORD_LO  = 9'h001;

    localparam int            GSW_BIT_HS_SEND  = 15;
    localparam int            GSW_BIT_HS_CONF  = 14;
    localparam int            GSW_BIT_VALID    = 13;
    localparam int            GSW_CODE_MSB     = 12;
    localparam int            GSW_CODE_LSB     = 8;

    localparam logic [4:0]    GSW_M_RETRANS    = 5'h00;
    localparam logic [4:0]    GSW_M_SINGLE     = 5'h01;
    localparam logic [4:0]    GSW_M_MULTIPLE   = 5'h02;
    localparam logic [4:0]    GSW_M_OVERRUN    = 5'h03;
    localparam logic [4:0]    GSW_M_OTHER      = 5'h04;
    localparam logic [4:0]    GSW_G_INVALID    = 5'h00;
    localparam logic [4:0]    GSW_G_FRAME      = 5'h01;
    localparam logic [4:0]    GSW_G_TIMEOUT    = 5'h02;
    localparam logic [4:0]    GSW_G_OVERRUN    = 5'h03;
    localparam logic [4:0]    GSW_G_OTHER      = 5'h04;
    localparam logic [4:0]    GSW_NO_ERROR     = 5'h1f;

    localparam logic [4:0]    GSW_RST_CODE     = 5'h1f;
    localparam logic [7:0]    GSW_RST_DATA     = 8'h00;
    localparam logic [15:0]   GSW_RST_WORD     = 16'h0000;

    typedef enum logic [1:0] {
        GSW_MODE_MASTER    = 2'h0,
        GSW_MODE_SECONDARY = 2'h1,
        GSW_MODE_GENERIC   = 2'h2
    } gsw_mode_type;

    typedef enum logic [2:0] {
        GSW_OFFLINE     = 3'h1,
        GSW_ONLINE_WAIT = 3'h2,
        GSW_EXCHANGE    = 3'h4
    } gsw_link_state_type;

endpackage

// file: shared/gsw_report_if.sv
`timescale 1ns/1ps
interface gsw_report_if;
    logic       report;
    logic [4:0] code;
    logic [7:0] data;

    modport src (
        output report,
        output code,
        output data
    );
    modport dst (
        input  report,
        input  code,
        input  data
    );
endinterface

// file: core/gsw_code_select.sv
`timescale 1ns/1ps
module gsw_code_select (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire gsw_pkg::gsw_mode_type mode,
    input  wire logic               retrans_inc,
    input  wire logic [7:0]         retrans_count,
    input  wire logic [7:0]         missing_count,
    input  wire logic [7:0]         missing_addr,
    input  wire logic               overrun,
    input  wire logic               other_error,
    input  wire logic [7:0]         fault_addr,
    input  wire logic               invalid_inc,
    input  wire logic [7:0]         invalid_count,
    input  wire logic               frame_error,
    input  wire logic               timeout_inc,
    input  wire logic [7:0]         timeout_count,
    input  wire logic               cause_clear,
    gsw_report_if.src               rep
);
    typedef struct packed {
        logic [7:0] prev_missing;
        logic       err_pending;
    } gsw_sel_state_type;

    gsw_sel_state_type sel_reg;
    gsw_sel_state_type sel_next;
    logic              master;
    logic              miss_chg;
    logic              clear_now;
    logic              is_err;

    always_comb begin
        sel_next    = sel_reg;
        master      = (mode != gsw_pkg::GSW_MODE_GENERIC);                   // [R17]
        miss_chg    = master && (missing_count != sel_reg.prev_missing);
        clear_now   = sel_reg.err_pending
                      && (cause_clear || (miss_chg && missing_count == 8'h00));
        rep.report  = 1'b1;
        rep.data    = 8'h00;
        is_err      = 1'b0;
        rep.code    = gsw_pkg::GSW_NO_ERROR;
        if (master) begin
            if (other_error) begin
                rep.code = gsw_pkg::GSW_M_OTHER;                            // [R10]
                rep.data = fault_addr;
                is_err   = 1'b1;
            end else if (miss_chg && missing_count == 8'h01) begin
                rep.code = gsw_pkg::GSW_M_SINGLE;                           // [R08]
                rep.data = missing_addr;
                is_err   = 1'b1;
            end else if (miss_chg && missing_count > 8'h01) begin
                rep.code = gsw_pkg::GSW_M_MULTIPLE;                         // [R09]
                rep.data = missing_count;
                is_err   = 1'b1;
            end else if (overrun) begin
                rep.code = gsw_pkg::GSW_M_OVERRUN;                          // [R10] [R12]
                rep.data = fault_addr;
            end else if (retrans_inc) begin
                rep.code = gsw_pkg::GSW_M_RETRANS;                          // [R07]
                rep.data = retrans_count;
            end else if (!clear_now) begin
                rep.report = 1'b0;
            end
        end else begin
            if (other_error) begin
                rep.code = gsw_pkg::GSW_G_OTHER;                            // [R16]
                is_err   = 1'b1;
            end else if (timeout_inc) begin
                rep.code = gsw_pkg::GSW_G_TIMEOUT;                          // [R15]
                rep.data = timeout_count;
                is_err   = 1'b1;
            end else if (invalid_inc) begin
                rep.code = gsw_pkg::GSW_G_INVALID;                          // [R13]
                rep.data = invalid_count;
                is_err   = 1'b1;
            end else if (overrun) begin
                rep.code = gsw_pkg::GSW_G_OVERRUN;                          // [R16]
            end else if (frame_error) begin
                rep.code = gsw_pkg::GSW_G_FRAME;                            // [R14]
            end else if (!clear_now) begin
                rep.report = 1'b0;
            end
        end
        if (is_err) begin
            sel_next.err_pending = 1'b1;
        end else if (rep.report && rep.code == gsw_pkg::GSW_NO_ERROR) begin
            sel_next.err_pending = 1'b0;                                    // [R11]
        end
        sel_next.prev_missing = missing_count;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_reg <= '0;
        end else begin
            sel_reg <= sel_next;
        end
    end

    default clocking sel_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    single_miss_a: assert property (master && !other_error && miss_chg                // [R08]
        && missing_count == 8'h01 |-> rep.code == gsw_pkg::GSW_M_SINGLE
        && rep.data == missing_addr)
        else $error("single missing node not reported");
    no_error_a: assert property (clear_now && !is_err && !overrun && !retrans_inc     // [R11]
        && !frame_error |-> rep.report && rep.code == gsw_pkg::GSW_NO_ERROR
        ##1 !sel_reg.err_pending)
        else $error("no-error report missing after cleared cause");
    generic_timeout_a: assert property (!master && !other_error && timeout_inc        // [R15]
        |-> rep.code == gsw_pkg::GSW_G_TIMEOUT && rep.data == timeout_count)
        else $error("offline timeout counter not reported");
endmodule

// file: core/gsw_valid_tracker.sv
`timescale 1ns/1ps
module gsw_valid_tracker (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  online,
    input  wire gsw_pkg::gsw_mode_type mode,
    input  wire logic                  all_done,
    output gsw_pkg::gsw_link_state_type link_state,
    output logic                       data_valid
);
    typedef struct packed {
        gsw_pkg::gsw_link_state_type state;
        logic                        valid;
    } gsw_trk_state_type;

    gsw_trk_state_type trk_reg;
    gsw_trk_state_type trk_next;

    always_comb begin
        trk_next = trk_reg;
        unique case (trk_reg.state)
            gsw_pkg::GSW_OFFLINE: begin
                trk_next.valid = 1'b0;
                if (online) begin
                    trk_next.state = gsw_pkg::GSW_ONLINE_WAIT;
                end
            end
            gsw_pkg::GSW_ONLINE_WAIT: begin
                trk_next.valid = 1'b0;                                      // [R19]
                if (!online) begin
                    trk_next.state = gsw_pkg::GSW_OFFLINE;
                end else if (mode != gsw_pkg::GSW_MODE_GENERIC && all_done) begin
                    trk_next.state = gsw_pkg::GSW_EXCHANGE;                 // [R03]
                    trk_next.valid = 1'b1;
                end
            end
            gsw_pkg::GSW_EXCHANGE: begin
                if (!online) begin
                    trk_next.state = gsw_pkg::GSW_OFFLINE;
                    trk_next.valid = 1'b0;
                end
            end
            default: begin
                trk_next.state = gsw_pkg::GSW_OFFLINE;
                trk_next.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trk_reg <= '{state: gsw_pkg::GSW_OFFLINE, valid: 1'b0};
        end else begin
            trk_reg <= trk_next;
        end
    end

    assign link_state = trk_reg.state;
    assign data_valid = trk_reg.valid && (mode != gsw_pkg::GSW_MODE_GENERIC);  // [R04]
endmodule

// file: core/gsw_status_word.sv
`timescale 1ns/1ps
module gsw_status_word (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  status_word_enable,
    input  wire gsw_pkg::gsw_mode_type mode,
    input  wire logic                  fieldbus_online_pin,
    input  wire logic                  status_handshake_send,
    input  wire logic                  status_handshake_confirm,
    input  wire logic                  all_done,
    input  wire logic                  retrans_inc,
    input  wire logic [7:0]            retrans_count,
    input  wire logic [7:0]            missing_count,
    input  wire logic [7:0]            missing_addr,
    input  wire logic                  overrun,
    input  wire logic                  other_error,
    input  wire logic [7:0]            fault_addr,
    input  wire logic                  invalid_inc,
    input  wire logic [7:0]            invalid_count,
    input  wire logic                  frame_error,
    input  wire logic                  timeout_inc,
    input  wire logic [7:0]            timeout_count,
    input  wire logic                  cause_clear,
    input  wire logic                  area_rd_en,
    input  wire logic [8:0]            area_rd_offset,
    input  wire logic [7:0]            area_app_byte,
    output logic [7:0]                 area_rd_data,
    output logic                       area_rd_valid,
    output logic [15:0]                status_word,
    output logic                       fieldbus_online
);
    // ******************************************************
    // State
    // ******************************************************
    typedef struct packed {
        logic       sync0;
        logic       sync1;
        logic       sync2;
        logic       online;
        logic       hs_send;
        logic       hs_confirm;
        logic [4:0] code;
        logic [7:0] data;
        logic [7:0] rd_data;
        logic       rd_valid;
    } gsw_top_state_type;

    gsw_top_state_type top_reg;
    gsw_top_state_type top_next;
    logic              data_valid;
    logic [15:0]       word;
    gsw_pkg::gsw_link_state_type link_state;

    gsw_report_if rep ();

    // ******************************************************
    // Event to code selection
    // ******************************************************
    gsw_code_select u_select (
        .clk           (clk),
        .rst           (rst),
        .mode          (mode),
        .retrans_inc   (retrans_inc),
        .retrans_count (retrans_count),
        .missing_count (missing_count),
        .missing_addr  (missing_addr),
        .overrun       (overrun),
        .other_error   (other_error),
        .fault_addr    (fault_addr),
        .invalid_inc   (invalid_inc),
        .invalid_count (invalid_count),
        .frame_error   (frame_error),
        .timeout_inc   (timeout_inc),
        .timeout_count (timeout_count),
        .cause_clear   (cause_clear),
        .rep           (rep)
    );

    // ******************************************************
    // Data valid tracking
    // ******************************************************
    gsw_valid_tracker u_tracker (
        .clk        (clk),
        .rst        (rst),
        .online     (top_reg.online),
        .mode       (mode),
        .all_done   (all_done),
        .link_state (link_state),
        .data_valid (data_valid)
    );

    // ******************************************************
    // Word assembly
    // ******************************************************
    always_comb begin
        word = gsw_pkg::GSW_RST_WORD;
        if (status_word_enable && top_reg.online) begin
            word[gsw_pkg::GSW_BIT_HS_SEND] = top_reg.hs_send;                // [R02]
            word[gsw_pkg::GSW_BIT_HS_CONF] = top_reg.hs_confirm;             // [R02]
            word[gsw_pkg::GSW_BIT_VALID]   = data_valid;                     // [R03] [R04]
            word[gsw_pkg::GSW_CODE_MSB:gsw_pkg::GSW_CODE_LSB] = top_reg.code; // [R05]
            word[7:0]                      = top_reg.data;                   // [R05]
        end
    end

    // ******************************************************
    // Next state
    // ******************************************************
    always_comb begin
        top_next       = top_reg;
        top_next.sync0 = fieldbus_online_pin;
        top_next.sync1 = top_reg.sync0;
        top_next.sync2 = top_reg.sync1;
        if (top_reg.sync1 == top_reg.sync2) begin
            top_next.online = top_reg.sync2;
        end
        top_next.hs_send    = status_handshake_send;
        top_next.hs_confirm = status_handshake_confirm;
        if (!top_reg.online) begin
            top_next.code = gsw_pkg::GSW_RST_CODE;
            top_next.data = gsw_pkg::GSW_RST_DATA;
        end else if (rep.report) begin
            top_next.code = rep.code;                                       // [R20]
            top_next.data = rep.data;                                       // [R20]
        end
        top_next.rd_valid = area_rd_en;
        if (area_rd_en) begin
            if (status_word_enable && area_rd_offset == gsw_pkg::GSW_OFS_WORD_HI) begin
                top_next.rd_data = word[15:8];                              // [R01] [R06]
            end else if (status_word_enable
                         && area_rd_offset == gsw_pkg::GSW_OFS_WORD_LO) begin
                top_next.rd_data = word[7:0];                               // [R01] [R06]
            end else begin
                top_next.rd_data = area_app_byte;                           // [R18]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            top_reg <= '{sync0: 1'b0, sync1: 1'b0, sync2: 1'b0, online: 1'b0,
                         hs_send: 1'b0, hs_confirm: 1'b0,
                         code: gsw_pkg::GSW_RST_CODE, data: gsw_pkg::GSW_RST_DATA,
                         rd_data: 8'h00, rd_valid: 1'b0};
        end else begin
            top_reg <= top_next;
        end
    end

    assign status_word     = word;
    assign area_rd_data    = top_reg.rd_data;
    assign area_rd_valid   = top_reg.rd_valid;
    assign fieldbus_online = top_reg.online;

    // ******************************************************
    // Checks
    // ******************************************************
    default clocking top_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence online_rise_s;
        !top_reg.online ##1 top_reg.online;
    endsequence

    sequence read_hi_s;
        area_rd_en && status_word_enable && area_rd_offset == gsw_pkg::GSW_OFS_WORD_HI;
    endsequence

    sequence read_lo_s;
        area_rd_en && status_word_enable && area_rd_offset == gsw_pkg::GSW_OFS_WORD_LO;
    endsequence

    high_byte_a: assert property (read_hi_s |=>                                       // [R06]
        area_rd_valid && area_rd_data == $past(status_word[15:8]))
        else $error("offset zero does not return high byte");

    low_byte_a: assert property (read_lo_s |=>                                        // [R01]
        area_rd_valid && area_rd_data == $past(status_word[7:0]))
        else $error("offset one does not return low byte");

    disabled_word_a: assert property (area_rd_en && !status_word_enable |=>           // [R18]
        area_rd_data == $past(area_app_byte))
        else $error("disabled word overlays application data");

    disabled_zero_a: assert property (!status_word_enable |-> status_word == 16'h0000) // [R18]
        else $error("disabled word not inactive");

    generic_valid_a: assert property (mode == gsw_pkg::GSW_MODE_GENERIC               // [R04]
        |-> !status_word[gsw_pkg::GSW_BIT_VALID])
        else $error("valid bit used in generic mode");

    online_clear_a: assert property (online_rise_s |-> !data_valid ##1 !data_valid)   // [R19]
        else $error("valid not cleared when coming online");

    valid_hold_a: assert property (data_valid && top_reg.online                       // [R03]
        ##1 top_reg.online && $stable(mode) |-> data_valid)
        else $error("valid bit dropped while online");

    valid_set_a: assert property (link_state == gsw_pkg::GSW_ONLINE_WAIT               // [R03]
        && top_reg.online && all_done && mode != gsw_pkg::GSW_MODE_GENERIC
        ##1 top_reg.online && $stable(mode) |-> data_valid)
        else $error("valid bit not set after all transactions");

    code_pair_a: assert property (top_reg.online && rep.report |=>                    // [R20]
        top_reg.code == $past(rep.code) && top_reg.data == $past(rep.data))
        else $error("code and data not updated together");

    handshake_a: assert property (status_word_enable && top_reg.online                // [R02]
        ##1 status_word_enable && top_reg.online
        |-> status_word[gsw_pkg::GSW_BIT_HS_SEND] == $past(status_handshake_send)
        && status_word[gsw_pkg::GSW_BIT_HS_CONF] == $past(status_handshake_confirm))
        else $error("handshake bits not in place");

    retrans_a: assert property (top_reg.online && mode != gsw_pkg::GSW_MODE_GENERIC   // [R07]
        && retrans_inc && !other_error && !overrun && missing_count == $past(missing_count)
        |=> top_reg.code == gsw_pkg::GSW_M_RETRANS
        && top_reg.data == $past(retrans_count))
        else $error("retransmission warning not reported");

    multi_miss_a: assert property (top_reg.online && mode != gsw_pkg::GSW_MODE_GENERIC // [R09]
        && !other_error && missing_count > 8'h01 && missing_count != $past(missing_count)
        |=> top_reg.code == gsw_pkg::GSW_M_MULTIPLE
        && top_reg.data == $past(missing_count))
        else $error("multiple missing nodes not reported");

    frame_a: assert property (top_reg.online && mode == gsw_pkg::GSW_MODE_GENERIC     // [R14]
        && frame_error && !other_error && !timeout_inc && !invalid_inc && !overrun
        |=> top_reg.code == gsw_pkg::GSW_G_FRAME && top_reg.data == 8'h00)
        else $error("frame error warning not reported");

    offline_reset_a: assert property (!top_reg.online |=>
        top_reg.code == gsw_pkg::GSW_RST_CODE)
        else $error("offline did not reset status code");
endmodule

// file: sim/gsw_host_model.sv
`timescale 1ns/1ps
module gsw_host_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [7:0]  rd_data,
    input  wire logic        rd_valid,
    output logic             rd_en,
    output logic [8:0]       rd_offset,
    output logic [15:0]      word,
    output logic             done
);
    initial begin
        rd_en = 1'b0;
        rd_offset = 9'h1ff;
        word = 16'h0000;
        done = 1'b0;
    end
    // Two back-to-back byte reads
    always begin
        @(posedge go);
        @(negedge clk) rd_en = 1'b1;
        rd_offset = 9'h000;
        @(negedge clk) rd_offset = 9'h001;
        @(negedge clk) rd_en = 1'b0;
        rd_offset = ~rd_offset;
        @(negedge clk) done = 1'b1;
        @(negedge go) done = 1'b0;
    end
    // First byte lands high
    always @(posedge clk) if (rd_valid) word <= {word[7:0], rd_data};
endmodule

// file: sim/gateway_status_word_bench.sv
`timescale 1ns/1ps
module gateway_status_word_bench;
    logic clk = 1'b0, rst = 1'b1, status_word_enable = 1'b0, fieldbus_online_pin = 1'b0;
    logic status_handshake_send = 1'b0, status_handshake_confirm = 1'b0, all_done = 1'b0;
    logic retrans_inc = 1'b0, overrun = 1'b0, other_error = 1'b0, invalid_inc = 1'b0;
    logic frame_error = 1'b0, timeout_inc = 1'b0, cause_clear = 1'b0, go = 1'b0;
    logic [7:0] retrans_count = 8'h05, missing_count = 8'h00, missing_addr = 8'h23;
    logic [7:0] fault_addr = 8'h44, invalid_count = 8'h07, timeout_count = 8'h09;
    logic [7:0] area_app_byte = 8'h5a, area_rd_data;
    logic [8:0] area_rd_offset;
    logic [15:0] status_word, word;
    logic area_rd_en, area_rd_valid, fieldbus_online, done;
    gsw_pkg::gsw_mode_type mode = gsw_pkg::GSW_MODE_MASTER;
    int num_errors = 0, n_checks = 0, cyc = 0;

    gsw_status_word u_dut (.clk, .rst, .status_word_enable, .mode, .fieldbus_online_pin,
        .status_handshake_send, .status_handshake_confirm, .all_done, .retrans_inc,
        .retrans_count, .missing_count, .missing_addr, .overrun, .other_error, .fault_addr,
        .invalid_inc, .invalid_count, .frame_error, .timeout_inc, .timeout_count,
        .cause_clear, .area_rd_en, .area_rd_offset, .area_app_byte, .area_rd_data,
        .area_rd_valid, .status_word, .fieldbus_online);
    gsw_host_model u_host (.clk, .go, .rd_data(area_rd_data), .rd_valid(area_rd_valid),
        .rd_en(area_rd_en), .rd_offset(area_rd_offset), .word, .done);

    always #20 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end

    task summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pulse at most one event input (none for k 7), check code and data one cycle on
    task ev(input int k, input logic [12:0] exp);
        case (k)
            0: retrans_inc = 1'b1;
            1: overrun = 1'b1;
            2: other_error = 1'b1;
            3: invalid_inc = 1'b1;
            4: frame_error = 1'b1;
            5: timeout_inc = 1'b1;
            6: cause_clear = 1'b1;
            default: ;
        endcase
        @(negedge clk);
        {retrans_inc, overrun, other_error, invalid_inc, frame_error, timeout_inc} = '0;
        cause_clear = 1'b0;
        chk({3'h0, status_word[12:0]}, {3'h0, exp});
    endtask
    task host_read(input logic [15:0] exp);
        go = 1'b1;
        for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk);
        @(negedge clk) chk(word, exp);
        go = 1'b0;
        @(negedge clk);
    endtask

    task t_master();
        status_word_enable = 1'b1;
        fieldbus_online_pin = 1'b1;
        repeat (6) @(negedge clk);
        chk({3'h0, status_word[12:0]}, 16'h1f00);
        ev(0, 13'h0005);
        missing_count = 8'h01;
        ev(7, 13'h0123);
        missing_count = 8'h03;
        ev(7, 13'h0203);
        ev(1, 13'h0344);
        ev(2, 13'h0444);
        ev(6, 13'h1f00);
        ev(1, 13'h0344);
        ev(6, 13'h0344);
        mode = gsw_pkg::GSW_MODE_SECONDARY;
        ev(0, 13'h0005);
        $display("master codes done");
    endtask
    task t_access();
        status_handshake_send = 1'b1;
        all_done = 1'b1;
        repeat (4) @(negedge clk);
        all_done = 1'b0;
        repeat (4) @(negedge clk);
        chk(status_word, 16'ha005);
        host_read(16'ha005);
        status_handshake_send = 1'b0;
        status_handshake_confirm = 1'b1;
        repeat (2) @(negedge clk);
        chk(status_word, 16'h6005);
        status_word_enable = 1'b0;
        repeat (2) @(negedge clk);
        chk(status_word, 16'h0000);
        host_read(16'h5a5a);
        status_word_enable = 1'b1;
        $display("access done");
    endtask
    task t_relink();
        fieldbus_online_pin = 1'b0;
        repeat (6) @(negedge clk);
        chk({15'h0, fieldbus_online}, 16'h0000);
        chk(status_word, 16'h0000);
        fieldbus_online_pin = 1'b1;
        repeat (6) @(negedge clk);
        chk(status_word, 16'h5f00);
        $display("relink done");
    endtask
    task t_generic();
        missing_count = 8'h00;
        all_done = 1'b1;
        ev(6, 13'h1f00);
        chk({15'h0, status_word[13]}, 16'h0001);
        mode = gsw_pkg::GSW_MODE_GENERIC;
        repeat (4) @(negedge clk);
        chk({15'h0, status_word[13]}, 16'h0000);
        ev(3, 13'h0007);
        ev(4, 13'h0100);
        ev(5, 13'h0209);
        ev(1, 13'h0300);
        ev(2, 13'h0400);
        ev(6, 13'h1f00);
        $display("generic done");
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(status_word, 16'h0000);
        t_master();
        t_access();
        t_relink();
        t_generic();
        summarize();
    end
endmodule
